/* include/lds_pkg.sv */
package lds_pkg;

  localparam int CLK_NS       = 4;
  localparam int SPI_HALF_NS  = 20;
  localparam int SPI_HALF_CYC = (SPI_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESP_TMO_NS  = 2000;
  localparam int RESP_TMO_CYC = RESP_TMO_NS / CLK_NS;

  localparam logic [3:0] SPI_DIV_LAST = 4'(SPI_HALF_CYC - 1);
  localparam logic [9:0] TMO_LAST     = 10'(RESP_TMO_CYC - 1);

  localparam int         FRAME_BYTES = 8;
  localparam logic [2:0] LAST_IDX    = 3'h7;
  localparam logic [2:0] LAST_BIT    = 3'h7;
  localparam int         IDX_NAD     = 0;
  localparam int         IDX_CMD     = 1;
  localparam int         IDX_P0      = 2;
  localparam int         IDX_P1      = 3;
  localparam int         IDX_P2      = 4;
  localparam int         IDX_P3      = 5;
  localparam int         IDX_P4      = 6;
  localparam int         IDX_P5      = 7;

  localparam logic [7:0] PID_REQ      = 8'h3c;
  localparam logic [7:0] PID_RESP     = 8'h3d;
  localparam logic [7:0] OWN_NAD      = 8'ha0;
  localparam logic [7:0] NAD_FREE_MIN = 8'h80;
  localparam logic [7:0] FILL_BYTE    = 8'hff;

  localparam logic [7:0] CMD_SPI = 8'h00;
  localparam logic [7:0] CMD_PWM = 8'h01;
  localparam logic [7:0] CMD_ADC = 8'h02;
  localparam logic [7:0] CMD_CTL = 8'h03;
  localparam logic [7:0] CMD_RPT = 8'h04;

  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_REQ_LO  = 8'h04;
  localparam logic [7:0] OFF_REQ_HI  = 8'h08;
  localparam logic [7:0] OFF_RESP_LO = 8'h0c;
  localparam logic [7:0] OFF_RESP_HI = 8'h10;
  localparam logic [7:0] OFF_STAT    = 8'h14;
  localparam logic [7:0] OFF_IRQ_ST  = 8'h18;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h1c;
  localparam logic [7:0] OFF_IRQ_EN  = 8'h20;

  localparam int CTRL_SEND  = 0;
  localparam int CTRL_POLL  = 1;
  localparam int IRQ_SENT   = 0;
  localparam int IRQ_RESP   = 1;
  localparam int IRQ_TMO    = 2;
  localparam int IRQ_BADNAD = 3;
  localparam int IRQ_W      = 4;

  typedef logic [7:0] lds_byte_t;

  typedef enum logic [4:0] {
    D_IDLE = 5'b00001,
    D_RX   = 5'b00010,
    D_EXEC = 5'b00100,
    D_SPI  = 5'b01000,
    D_TX   = 5'b10000
  } lds_dstate_e;

  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_DATA = 3'b010,
    H_WAIT = 3'b100
  } lds_hstate_e;

endpackage

/* include/lds_link_if.sv */
`timescale 1ns/100ps
interface lds_link_if (
  input wire logic pclk,
  input wire logic presetn
);
  logic       hdr_stb;
  logic [7:0] hdr_pid;
  logic       m_stb;
  logic [7:0] m_data;
  logic       s_stb;
  logic [7:0] s_data;

  modport master (
    input  pclk, presetn, s_stb, s_data,
    output hdr_stb, hdr_pid, m_stb, m_data
  );
  modport slave (
    input  pclk, presetn, hdr_stb, hdr_pid, m_stb, m_data,
    output s_stb, s_data
  );
endinterface

/* verilog/lds_spi_xchg.sv */
`timescale 1ns/100ps
module lds_spi_xchg
  import lds_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic start,
  input  wire logic [7:0] tx_byte,
  input  wire logic miso_q,
  output logic      sclk,
  output logic      mosi,
  output logic      cs_n,
  output logic      done,
  output logic [7:0] rx_byte
);
  logic       busy_reg;
  logic [3:0] div_reg;
  logic [2:0] bit_reg;
  logic [7:0] sh_reg;
  logic       tick;

  assign tick = busy_reg && (div_reg == SPI_DIV_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 4'h0;
    end else if (!busy_reg || tick) begin
      div_reg <= 4'h0;
    end else begin
      div_reg <= div_reg + 4'h1;
    end
  end

  // mode 0, msb first: sample on rising sclk, shift out on falling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 1'b0;
      sclk     <= 1'b0;
      mosi     <= 1'b0;
      cs_n     <= 1'b1;
      bit_reg  <= 3'h0;
      sh_reg   <= 8'h00;
      done     <= 1'b0;
      rx_byte  <= 8'h00;
    end else begin
      done <= 1'b0;
      if (start && !busy_reg) begin
        busy_reg <= 1'b1;
        cs_n     <= 1'b0;
        sh_reg   <= tx_byte;
        mosi     <= tx_byte[7];
        bit_reg  <= 3'h0;
      end else if (tick && !sclk) begin
        sclk   <= 1'b1;
        sh_reg <= {sh_reg[6:0], miso_q};
      end else if (tick) begin
        sclk <= 1'b0;
        if (bit_reg == LAST_BIT) begin
          busy_reg <= 1'b0;
          cs_n     <= 1'b1;
          done     <= 1'b1;
          rx_byte  <= sh_reg;
        end else begin
          bit_reg <= bit_reg + 3'h1;
          mosi    <= sh_reg[7];
        end
      end
    end
  end
endmodule

/* verilog/lds_dev_end.sv */
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module lds_dev_end
  import lds_pkg::*;
(
  lds_link_if.slave        lnk,
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        miso,
  input  wire logic [15:0] adc0,
  input  wire logic [15:0] adc1,
  input  wire logic [7:0]  wd_pin_cfg,
  input  wire logic [7:0]  reset_seen,
  input  wire logic [7:0]  irq_state,
  output logic             spi_sclk,
  output logic             spi_mosi,
  output logic             spi_cs_n,
  output logic [15:0]      pwm_freq,
  output logic [15:0]      pwm_duty,
  output logic [7:0]       pwm_range,
  output logic             pwm_load,
  output logic [7:0]       wd_stop_clear,
  output logic [7:0]       accept_reset,
  output logic [7:0]       accept_irq
);
  lds_dstate_e state_reg;
  lds_dstate_e state_next;
  logic [2:0]  cnt_reg;
  lds_byte_t   rx_reg  [FRAME_BYTES];
  lds_byte_t   tx_reg  [FRAME_BYTES];
  lds_byte_t   tx_next [FRAME_BYTES];
  logic        tx_load;
  logic        pend_reg;
  logic        poll_reg;
  logic        miso_s1;
  logic        miso_s2;
  logic        miso_s3;
  logic        miso_q;
  logic        spi_done;
  lds_byte_t   spi_rx;
  logic        s_stb_reg;
  lds_byte_t   s_data_reg;
  logic        hdr_req;
  logic        hdr_resp;
  logic        addr_ok;
  logic        pay_ff;
  logic        exec_spi;
  logic        exec_pwm;
  logic        exec_adc;
  logic        exec_ctl;
  logic        exec_rpt;

  assign lnk.s_stb  = s_stb_reg;
  assign lnk.s_data = s_data_reg;

  assign hdr_req  = lnk.hdr_stb && (lnk.hdr_pid == PID_REQ);
  assign hdr_resp = lnk.hdr_stb && (lnk.hdr_pid == PID_RESP);

  // only the own free-range address is served
  assign addr_ok = (rx_reg[IDX_NAD] == OWN_NAD) && (rx_reg[IDX_NAD] >= NAD_FREE_MIN);

  always_comb begin
    pay_ff = 1'b1;
    for (int i = IDX_P0; i < FRAME_BYTES; i++) begin
      if (rx_reg[i] != FILL_BYTE) begin
        pay_ff = 1'b0;
      end
    end
  end

  // command decode; codes above the report command fall through unused
  assign exec_spi = (state_reg == D_EXEC) && addr_ok && (rx_reg[IDX_CMD] == CMD_SPI);
  assign exec_pwm = (state_reg == D_EXEC) && addr_ok && (rx_reg[IDX_CMD] == CMD_PWM);
  assign exec_adc = (state_reg == D_EXEC) && addr_ok && (rx_reg[IDX_CMD] == CMD_ADC);
  assign exec_ctl = (state_reg == D_EXEC) && addr_ok && (rx_reg[IDX_CMD] == CMD_CTL);
  assign exec_rpt = (state_reg == D_EXEC) && addr_ok && (rx_reg[IDX_CMD] == CMD_RPT);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      D_IDLE: begin
        if (hdr_req) begin
          state_next = D_RX;
        end else if ((hdr_resp || poll_reg) && pend_reg) begin
          state_next = D_TX;
        end
      end
      D_RX: begin
        if (lnk.hdr_stb) begin
          state_next = D_IDLE;
        end else if (lnk.m_stb && (cnt_reg == LAST_IDX)) begin
          state_next = D_EXEC;
        end
      end
      D_EXEC: begin
        state_next = exec_spi ? D_SPI : D_IDLE;
      end
      D_SPI: begin
        if (spi_done) begin
          state_next = D_IDLE;
        end
      end
      D_TX: begin
        if (cnt_reg == LAST_IDX) begin
          state_next = D_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= D_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 3'h0;
    end else if ((state_reg == D_TX) || ((state_reg == D_RX) && lnk.m_stb)) begin
      cnt_reg <= cnt_reg + 3'h1;
    end else if (state_reg != D_RX) begin
      cnt_reg <= 3'h0;
    end
  end

  // byte 0 is the address, byte 1 the command, then the payload
  generate
    for (genvar g = 0; g < FRAME_BYTES; g++) begin : g_rx
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rx_reg[g] <= FILL_BYTE;
        end else if ((state_reg == D_RX) && lnk.m_stb && (cnt_reg == 3'(g))) begin
          rx_reg[g] <= lnk.m_data;
        end
      end
    end
  endgenerate

  // a header for the response that lands while busy is served afterwards
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      poll_reg <= 1'b0;
    end else if ((state_reg == D_IDLE) || (state_reg == D_TX)) begin
      poll_reg <= 1'b0;
    end else if (hdr_resp) begin
      poll_reg <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
      miso_s3 <= 1'b0;
      miso_q  <= 1'b0;
    end else begin
      miso_s1 <= miso;
      miso_s2 <= miso_s1;
      miso_s3 <= miso_s2;
      if (miso_s2 == miso_s3) begin
        miso_q <= miso_s3;
      end
    end
  end

  lds_spi_xchg u_spi (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (exec_spi),
    .tx_byte (rx_reg[IDX_P0]),
    .miso_q  (miso_q),
    .sclk    (spi_sclk),
    .mosi    (spi_mosi),
    .cs_n    (spi_cs_n),
    .done    (spi_done),
    .rx_byte (spi_rx)
  );

  // response image: own address first, then the command it answers
  always_comb begin
    tx_load = 1'b0;
    for (int i = 0; i < FRAME_BYTES; i++) begin
      tx_next[i] = FILL_BYTE;
    end
    tx_next[IDX_NAD] = OWN_NAD;
    tx_next[IDX_CMD] = rx_reg[IDX_CMD];
    if ((state_reg == D_SPI) && spi_done) begin
      tx_load          = 1'b1;
      tx_next[IDX_CMD] = CMD_SPI;
      tx_next[IDX_P0]  = spi_rx;
    end else if (exec_adc && pay_ff) begin
      tx_load         = 1'b1;
      tx_next[IDX_P0] = adc0[7:0];
      tx_next[IDX_P1] = adc0[15:8];
      tx_next[IDX_P2] = adc1[7:0];
      tx_next[IDX_P3] = adc1[15:8];
    end else if (exec_rpt) begin
      tx_load         = 1'b1;
      tx_next[IDX_P0] = wd_pin_cfg;
      tx_next[IDX_P1] = reset_seen;
      tx_next[IDX_P2] = irq_state;
    end
  end

  generate
    for (genvar g = 0; g < FRAME_BYTES; g++) begin : g_tx
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          tx_reg[g] <= FILL_BYTE;
        end else if (tx_load) begin
          tx_reg[g] <= tx_next[g];
        end
      end
    end
  endgenerate

  // a new result wins over the end of a transmission in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg <= 1'b0;
    end else if (tx_load) begin
      pend_reg <= 1'b1;
    end else if (exec_spi || ((state_reg == D_TX) && (cnt_reg == LAST_IDX))) begin
      pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_stb_reg  <= 1'b0;
      s_data_reg <= 8'h00;
    end else begin
      s_stb_reg  <= (state_reg == D_TX);
      s_data_reg <= tx_reg[cnt_reg];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_freq  <= 16'h0000;
      pwm_duty  <= 16'h0000;
      pwm_range <= 8'h00;
      pwm_load  <= 1'b0;
    end else begin
      pwm_load <= exec_pwm;
      if (exec_pwm) begin
        pwm_freq  <= {rx_reg[IDX_P1], rx_reg[IDX_P0]};
        pwm_duty  <= {rx_reg[IDX_P3], rx_reg[IDX_P2]};
        pwm_range <= rx_reg[IDX_P4];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_stop_clear <= 8'h00;
      accept_reset  <= 8'h00;
      accept_irq    <= 8'h00;
    end else if (exec_ctl) begin
      wd_stop_clear <= rx_reg[IDX_P0];
      accept_reset  <= rx_reg[IDX_P1];
      accept_irq    <= rx_reg[IDX_P2];
    end
  end
endmodule

/* verilog/lds_host_end.sv */
`timescale 1ns/100ps
module lds_host_end
  import lds_pkg::*;
(
  lds_link_if.master       lnk,
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);
  lds_hstate_e      state_reg;
  logic [2:0]       cnt_reg;
  logic [9:0]       tmr_reg;
  logic [63:0]      req_reg;
  logic [63:0]      resp_reg;
  logic [IRQ_W-1:0] st_reg;
  logic [IRQ_W-1:0] en_reg;
  logic [IRQ_W-1:0] evt;
  logic [IRQ_W-1:0] clr;
  logic             hdr_stb_reg;
  lds_byte_t        hdr_pid_reg;
  logic             m_stb_reg;
  lds_byte_t        m_data_reg;
  logic             setup;
  logic             wr_fire;
  logic             mapped;
  logic [31:0]      rd_mux;
  logic             send_go;
  logic             poll_go;
  logic             nad_ok;

  assign lnk.hdr_stb = hdr_stb_reg;
  assign lnk.hdr_pid = hdr_pid_reg;
  assign lnk.m_stb   = m_stb_reg;
  assign lnk.m_data  = m_data_reg;

  assign setup   = psel && !penable;
  assign wr_fire = psel && penable && pready && pwrite;
  assign nad_ok  = req_reg[7:0] >= NAD_FREE_MIN;
  assign send_go = wr_fire && (paddr == OFF_CTRL) && pwdata[CTRL_SEND] && (state_reg == H_IDLE);
  assign poll_go = wr_fire && (paddr == OFF_CTRL) && pwdata[CTRL_POLL] && (state_reg == H_IDLE)
                   && !pwdata[CTRL_SEND];
  assign clr     = (wr_fire && (paddr == OFF_IRQ_CLR)) ? pwdata[IRQ_W-1:0] : '0;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFF_CTRL:    rd_mux = 32'h0000_0000;
      OFF_REQ_LO:  rd_mux = req_reg[31:0];
      OFF_REQ_HI:  rd_mux = req_reg[63:32];
      OFF_RESP_LO: rd_mux = resp_reg[31:0];
      OFF_RESP_HI: rd_mux = resp_reg[63:32];
      OFF_STAT:    rd_mux = {31'h0, state_reg != H_IDLE};
      OFF_IRQ_ST:  rd_mux = {{(32-IRQ_W){1'b0}}, st_reg};
      OFF_IRQ_CLR: rd_mux = 32'h0000_0000;
      OFF_IRQ_EN:  rd_mux = {{(32-IRQ_W){1'b0}}, en_reg};
      default:     mapped = 1'b0;
    endcase
  end

  // no wait state: answer in the cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      if (setup) begin
        prdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_reg <= {8{FILL_BYTE}};
      en_reg  <= '0;
    end else if (wr_fire) begin
      if (paddr == OFF_REQ_LO) begin
        req_reg[31:0] <= pwdata;
      end
      if (paddr == OFF_REQ_HI) begin
        req_reg[63:32] <= pwdata;
      end
      if (paddr == OFF_IRQ_EN) begin
        en_reg <= pwdata[IRQ_W-1:0];
      end
    end
  end

  always_comb begin
    evt             = '0;
    evt[IRQ_BADNAD] = send_go && !nad_ok;
    evt[IRQ_SENT]   = (state_reg == H_DATA) && (cnt_reg == LAST_IDX);
    evt[IRQ_RESP]   = (state_reg == H_WAIT) && lnk.s_stb && (cnt_reg == LAST_IDX);
    evt[IRQ_TMO]    = (state_reg == H_WAIT) && !lnk.s_stb && (tmr_reg == TMO_LAST);
  end

  // sticky status: a new event beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      irq    <= 1'b0;
    end else begin
      st_reg <= (st_reg & ~clr) | evt;
      irq    <= |(st_reg & en_reg);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg   <= H_IDLE;
      cnt_reg     <= 3'h0;
      tmr_reg     <= 10'h000;
      hdr_stb_reg <= 1'b0;
      hdr_pid_reg <= 8'h00;
      m_stb_reg   <= 1'b0;
      m_data_reg  <= 8'h00;
      resp_reg    <= {8{FILL_BYTE}};
    end else begin
      hdr_stb_reg <= 1'b0;
      m_stb_reg   <= 1'b0;
      unique case (state_reg)
        H_IDLE: begin
          cnt_reg <= 3'h0;
          tmr_reg <= 10'h000;
          if (send_go && nad_ok) begin
            hdr_stb_reg <= 1'b1;
            hdr_pid_reg <= PID_REQ;
            state_reg   <= H_DATA;
          end else if (poll_go) begin
            hdr_stb_reg <= 1'b1;
            hdr_pid_reg <= PID_RESP;
            state_reg   <= H_WAIT;
          end
        end
        H_DATA: begin
          m_stb_reg  <= 1'b1;
          m_data_reg <= req_reg[{cnt_reg, 3'b000} +: 8];
          cnt_reg    <= cnt_reg + 3'h1;
          if (cnt_reg == LAST_IDX) begin
            state_reg <= H_IDLE;
          end
        end
        H_WAIT: begin
          if (lnk.s_stb) begin
            resp_reg[{cnt_reg, 3'b000} +: 8] <= lnk.s_data;
            cnt_reg <= cnt_reg + 3'h1;
            tmr_reg <= 10'h000;
            if (cnt_reg == LAST_IDX) begin
              state_reg <= H_IDLE;
            end
          end else if (tmr_reg == TMO_LAST) begin
            state_reg <= H_IDLE;
          end else begin
            tmr_reg <= tmr_reg + 10'h001;
          end
        end
      endcase
    end
  end
endmodule

/* bench/lds_link_asserts.sv */
`timescale 1ns/100ps
module lds_link_asserts
  import lds_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       hdr_stb,
  input wire logic [7:0] hdr_pid,
  input wire logic       m_stb,
  input wire logic [7:0] m_data,
  input wire logic       s_stb,
  input wire logic [7:0] s_data
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_hdr_pid; hdr_stb |-> (hdr_pid == PID_REQ || hdr_pid == PID_RESP); endproperty
  a_hdr_pid: assert property (p_hdr_pid) else $error("bad header id");
  property p_req_len; hdr_stb && hdr_pid == PID_REQ |=> m_stb[*8] ##1 !m_stb; endproperty
  a_req_len: assert property (p_req_len) else $error("request not eight bytes");
  property p_req_nad; hdr_stb && hdr_pid == PID_REQ |=> m_data >= NAD_FREE_MIN; endproperty
  a_req_nad: assert property (p_req_nad) else $error("request address not free");
  property p_resp_len; $rose(s_stb) |-> s_stb[*8] ##1 !s_stb; endproperty
  a_resp_len: assert property (p_resp_len) else $error("response not eight bytes");
  property p_resp_nad; $rose(s_stb) |-> s_data == OWN_NAD; endproperty
  a_resp_nad: assert property (p_resp_nad) else $error("response address wrong");
  property p_resp_cmd;
    $rose(s_stb) |=> (s_data == CMD_SPI || s_data == CMD_ADC || s_data == CMD_RPT);
  endproperty
  a_resp_cmd: assert property (p_resp_cmd) else $error("response command wrong");
  property p_spi_fill; $rose(s_stb) ##1 s_data == CMD_SPI |-> ##2 (s_data == FILL_BYTE)[*5];
  endproperty
  a_spi_fill: assert property (p_spi_fill) else $error("spi fill wrong");
  property p_adc_fill; $rose(s_stb) ##1 s_data == CMD_ADC |-> ##5 (s_data == FILL_BYTE)[*2];
  endproperty
  a_adc_fill: assert property (p_adc_fill) else $error("adc fill wrong");
  property p_rpt_fill; $rose(s_stb) ##1 s_data == CMD_RPT |-> ##4 (s_data == FILL_BYTE)[*3];
  endproperty
  a_rpt_fill: assert property (p_rpt_fill) else $error("report fill wrong");
endmodule

/* bench/tb_lin_diag_command_slave.sv */
`timescale 1ns/100ps
module tb_lin_diag_command_slave
  import lds_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, miso, irq, pready, pslverr, perr;
  logic        spi_sclk, spi_mosi, spi_cs_n, pwm_load;
  logic [7:0]  paddr, wd_pin_cfg, reset_seen, irq_state, spi_reply, mosi_cap, pwm_range;
  logic [7:0]  wd_stop_clear, accept_reset, accept_irq;
  logic [31:0] pwdata, prdata, rd, st;
  logic [15:0] adc0, adc1, pwm_freq, pwm_duty, seed;
  logic [3:0]  irq_en;
  logic [2:0]  bit_cnt = 3'h0;
  int          err_count, cmp_count;
  int          pwm_pulses = 0;

  lds_link_if lnk (.pclk(pclk), .presetn(presetn));
  lds_host_end lds_host_end_inst (.lnk(lnk), .pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));
  lds_dev_end lds_dev_end_inst (.lnk(lnk), .pclk(pclk), .presetn(presetn), .miso(miso),
    .adc0(adc0), .adc1(adc1), .wd_pin_cfg(wd_pin_cfg), .reset_seen(reset_seen),
    .irq_state(irq_state), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_cs_n(spi_cs_n),
    .pwm_freq(pwm_freq), .pwm_duty(pwm_duty), .pwm_range(pwm_range), .pwm_load(pwm_load),
    .wd_stop_clear(wd_stop_clear), .accept_reset(accept_reset), .accept_irq(accept_irq));
  lds_link_asserts lds_link_asserts_inst (.pclk(pclk), .presetn(presetn),
    .hdr_stb(lnk.hdr_stb), .hdr_pid(lnk.hdr_pid), .m_stb(lnk.m_stb), .m_data(lnk.m_data),
    .s_stb(lnk.s_stb), .s_data(lnk.s_data));

  always #2 pclk = ~pclk;

  // basis chip stand-in: next miso bit right at falling sclk, mosi taken at rising sclk
  always @(negedge spi_sclk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      bit_cnt <= 3'h0;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
    end
  end
  always @(posedge spi_sclk) begin
    if (!spi_cs_n) begin
      mosi_cap <= {mosi_cap[6:0], spi_mosi};
    end
  end
  always @(posedge pclk) begin
    if (pwm_load === 1'b1) begin
      pwm_pulses <= pwm_pulses + 1;
    end
  end
  // released line wanders instead of holding the last bit
  assign miso = spi_cs_n ? seed[0] : spi_reply[3'h7 - bit_cnt];

  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [63:0] exp_resp(input lds_byte_t c, b0, b1, b2, b3);
    return {16'hffff, b3, b2, b1, b0, c, OWN_NAD};
  endfunction

  task automatic report_and_stop;
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cmd(input logic [31:0] lo, input logic [31:0] hi, input logic [1:0] c);
    int n;
    apb(1'b1, OFF_REQ_LO, lo);
    apb(1'b1, OFF_REQ_HI, hi);
    apb(1'b1, OFF_CTRL, {30'h0, c});
    n = 0;
    rd = 32'h1;
    while (rd[0] !== 1'b0 && n < 400) begin
      apb(1'b0, OFF_STAT, 32'h0);
      n++;
    end
    if (n == 400) err_count++;
    apb(1'b0, OFF_IRQ_ST, 32'h0);
    st = rd;
    chk(64'(irq), 64'(|(st[3:0] & irq_en)));
    apb(1'b1, OFF_IRQ_CLR, 32'hf);
  endtask

  task automatic send(input lds_byte_t node_address_byte, input lds_byte_t c, input logic [47:0] p);
    cmd({p[15:0], c, node_address_byte}, p[47:16], 2'h1);
    chk(64'(st[3:0]), (node_address_byte < NAD_FREE_MIN) ? 64'h8 : 64'h1);
  endtask

  // an expectation of zero means the device must stay silent
  task automatic poll(input logic [63:0] exp);
    logic [31:0] lo;
    cmd(32'h0, 32'h0, 2'h2);
    chk(64'(st[2:1]), (exp === 64'h0) ? 64'h2 : 64'h1);
    if (exp !== 64'h0) begin
      apb(1'b0, OFF_RESP_LO, 32'h0);
      lo = rd;
      apb(1'b0, OFF_RESP_HI, 32'h0);
      chk({rd, lo}, exp);
    end
  endtask

  initial begin
    #(4 * 60000);
    err_count++;
    report_and_stop;
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {adc0, adc1, wd_pin_cfg, reset_seen, irq_state, spi_reply} = '0;
    seed = 16'd22;
    irq_en = 4'h0;
    err_count = 0;
    cmp_count = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_REQ_LO, 32'h0);
    chk(64'(rd), 64'hffffffff);
    apb(1'b0, 8'h40, 32'h0);
    chk(64'(perr), 64'h1);
    apb(1'b1, OFF_IRQ_EN, 32'hf);
    irq_en = 4'hf;
    for (int i = 0; i < 4; i++) begin
      seed = nx(seed);
      spi_reply <= (i == 0) ? 8'h00 : seed[15:8];
      send(OWN_NAD, CMD_SPI, {40'hffffffffff, (i == 0) ? 8'hff : seed[7:0]});
      poll(exp_resp(CMD_SPI, (i == 0) ? 8'h00 : seed[15:8], 8'hff, 8'hff, 8'hff));
      chk(64'(mosi_cap), (i == 0) ? 64'hff : 64'(seed[7:0]));
    end
    poll(64'h0);
    seed = nx(seed);
    send(OWN_NAD, CMD_PWM, {8'hff, seed[11:4], ~seed, seed});
    chk({pwm_range, pwm_duty, pwm_freq}, 64'({seed[11:4], ~seed, seed}));
    chk(64'(pwm_pulses), 64'h1);
    poll(64'h0);
    seed = nx(seed);
    adc0 <= seed;
    adc1 <= ~seed;
    send(OWN_NAD, CMD_ADC, {48{1'b1}});
    poll(exp_resp(CMD_ADC, seed[7:0], seed[15:8], ~seed[7:0], ~seed[15:8]));
    send(OWN_NAD, CMD_ADC, 48'hfffffffffffe);
    poll(64'h0);
    seed = nx(seed);
    send(OWN_NAD, CMD_CTL, {24'hffffff, seed[7:0], seed[15:8], ~seed[7:0]});
    chk({wd_stop_clear, accept_reset, accept_irq}, 64'({~seed[7:0], seed[15:8], seed[7:0]}));
    poll(64'h0);
    seed = nx(seed);
    wd_pin_cfg <= seed[7:0];
    reset_seen <= seed[15:8];
    irq_state <= ~seed[7:0];
    send(OWN_NAD, CMD_RPT, {48{1'b1}});
    poll(exp_resp(CMD_RPT, seed[7:0], seed[15:8], ~seed[7:0], 8'hff));
    send(8'h80, CMD_RPT, {48{1'b1}});
    poll(64'h0);
    send(OWN_NAD, 8'h05, {48{1'b1}});
    poll(64'h0);
    send(8'h7f, CMD_RPT, {48{1'b1}});
    apb(1'b1, OFF_IRQ_EN, 32'h0);
    irq_en = 4'h0;
    send(OWN_NAD, CMD_CTL, {48{1'b1}});
    report_and_stop;
  end
endmodule
